// File: logic/adcc_conversion_control.sv
// adcc_conversion_control: control/status register and sequencing of the 8-bit converter
// Function
// - pin start honoured only with external enable set
// - setting start bit begins selected-input conversion
// - start bit reads one while busy
// - end clears start bit and sets done on the same edge
// - both-set state never occurs
// - software cannot clear the start bit
// - done set by hardware, cleared by software
// - starts ignored while converting
// - starts ignored while result pending
// - start only when done and busy clear
// - time select picks 24 or 48 cycles
// - first six cycles sample the input
// - channel field picks one of four inputs
// - channel writable only when fully idle
// - power-off bit cuts the reference network
// - conversion runs on while CPU idles
// - result register frozen while done set
// - power-down aborts; pending result kept
`timescale 1ns/1ns
module adcc_conversion_control
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,

  // avalon-mm slave
  input wire logic [adcc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [adcc_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [adcc_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,

  // external start pin
  input wire logic extStartPin,

  // system power state
  input wire logic powerDownMode,

  // analog core and input multiplexer
  input wire logic [adcc_pkg::REG_W-1:0] coreResult,
  output logic [adcc_pkg::CHAN_W-1:0] muxSelect,
  output logic referencePowerOff,
  output logic sampleEnable,
  output logic convertActive,

  // completion request towards the interrupt controller
  output logic conversionDone
);

  import adcc_pkg::*;

  // =====================================================
  // register state
  logic [CHAN_W-1:0] channelSelect_r;
  logic convTimeSelect_r;
  logic startBusy_r;
  logic conversionDoneFlag_r;
  logic extStartEnable_r;
  logic referencePowerOff_r;
  logic [REG_W-1:0] conversionResult_r;
  adcc_state_type state_r;
  adcc_state_type state_nxt;

  // bus state
  logic waitReq_r;
  logic [DATA_W-1:0] readData_r;

  // =====================================================
  // internal nets
  logic busAccept;
  logic ctrlWrite;
  logic swStart;
  logic extEvent;
  logic extStart;
  logic converterFree;
  logic startGo;
  logic samplePhase;
  logic lastCycle;
  logic convEnd;
  logic convAbort;
  logic longSelNow;
  logic [REG_W-1:0] ctrlImage;
  logic [REG_W-1:0] statusImage;
  logic [DATA_W-1:0] readMux;

  // =====================================================
  // avalon-mm handshake
  // one wait cycle per access keeps readdata a plain register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitReq_r <= 1'b1;
    end else if ((read | write) & waitReq_r) begin
      waitReq_r <= 1'b0;
    end else begin
      waitReq_r <= 1'b1;
    end
  end

  assign busAccept = (read | write) & ~waitReq_r;
  assign ctrlWrite = write & busAccept & (address == CTRL_ADDR) & byteenable[0];

  // =====================================================
  // read images
  always_comb begin
    ctrlImage = '0;
    ctrlImage[CHAN_HI_BIT:CHAN_LO_BIT] = channelSelect_r;
    ctrlImage[TIME_SEL_BIT] = convTimeSelect_r;
    ctrlImage[BUSY_BIT] = startBusy_r;
    ctrlImage[DONE_BIT] = conversionDoneFlag_r;
    ctrlImage[EXT_EN_BIT] = extStartEnable_r;
    ctrlImage[REF_OFF_BIT] = referencePowerOff_r;
  end

  always_comb begin
    statusImage = '0;
    statusImage[STATE_LO_BIT+1:STATE_LO_BIT] = state_r;
    statusImage[SAMPLING_BIT] = samplePhase;
  end

  // unmapped addresses read zero and ignore writes
  always_comb begin
    readMux = '0;
    unique case (address)
      CTRL_ADDR: readMux[REG_W-1:0] = ctrlImage;
      RESULT_ADDR: readMux[REG_W-1:0] = conversionResult_r;
      STATUS_ADDR: readMux[REG_W-1:0] = statusImage;
      default: readMux = '0;
    endcase
  end

  // captured in the wait cycle, held through the accepting cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readData_r <= RDATA_RESET;
    end else if (read & waitReq_r) begin
      readData_r <= readMux;
    end
  end

  // =====================================================
  // start sources
  adcc_start_sync u_start_sync (
    .clk(clk),
    .rst(rst),
    .pinIn(extStartPin),
    .riseEvent(extEvent)
  );

  assign swStart = ctrlWrite & writedata[BUSY_BIT];
  assign extStart = extEvent & extStartEnable_r;
  // both flags clear and not being put to sleep
  assign converterFree = ~startBusy_r & ~conversionDoneFlag_r & ~powerDownMode;
  // requests seen while busy or pending are simply lost
  assign startGo = (swStart | extStart) & converterFree;

  // time select written in the same access applies to that start
  assign longSelNow = ctrlWrite ? writedata[TIME_SEL_BIT] : convTimeSelect_r;

  // =====================================================
  // conversion timer
  // runs on the peripheral clock, so a halted cpu does not stop it
  adcc_conv_timer u_conv_timer (
    .clk(clk),
    .rst(rst),
    .startPulse(startGo),
    .abortReq(convAbort),
    .longSel(longSelNow),
    .samplePhase(samplePhase),
    .lastCycle(lastCycle)
  );

  assign convAbort = powerDownMode & startBusy_r;
  assign convEnd = lastCycle & startBusy_r & ~powerDownMode;

  // =====================================================
  // phase tracking
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ADCC_IDLE: begin
        if (startGo) begin
          state_nxt = ADCC_SAMPLE;
        end
      end
      ADCC_SAMPLE: begin
        if (convAbort) begin
          state_nxt = ADCC_IDLE;
        end else if (~samplePhase) begin
          state_nxt = ADCC_CONVERT;
        end
      end
      ADCC_CONVERT: begin
        if (convAbort | convEnd) begin
          state_nxt = ADCC_IDLE;
        end
      end
      default: state_nxt = ADCC_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ADCC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // =====================================================
  // start/busy bit
  // busy and done change on the same edge, so the both-set
  // state never appears at all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      startBusy_r <= 1'b0;
    end else if (convEnd | convAbort) begin
      startBusy_r <= 1'b0;
    end else if (startGo) begin
      startBusy_r <= 1'b1;
    end
    // a written zero is never looked at here
  end

  // =====================================================
  // completion flag
  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversionDoneFlag_r <= 1'b0;
    end else if (convEnd) begin
      conversionDoneFlag_r <= 1'b1;
    end else if (ctrlWrite & ~writedata[DONE_BIT]) begin
      conversionDoneFlag_r <= 1'b0;
    end
  end

  // =====================================================
  // result register
  // only loaded at an end, which cannot occur while done is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conversionResult_r <= RESULT_RESET;
    end else if (convEnd) begin
      conversionResult_r <= coreResult;
    end
  end

  // =====================================================
  // channel select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channelSelect_r <= CHAN_RESET;
    end else if (ctrlWrite & ~startBusy_r & ~conversionDoneFlag_r) begin
      channelSelect_r <= writedata[CHAN_HI_BIT:CHAN_LO_BIT];
    end
  end

  // =====================================================
  // plain control bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      convTimeSelect_r <= 1'b0;
      extStartEnable_r <= 1'b0;
      referencePowerOff_r <= 1'b0;
    end else if (ctrlWrite) begin
      convTimeSelect_r <= writedata[TIME_SEL_BIT];
      extStartEnable_r <= writedata[EXT_EN_BIT];
      referencePowerOff_r <= writedata[REF_OFF_BIT];
    end
  end

  // =====================================================
  // core-facing outputs, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sampleEnable <= 1'b0;
    end else begin
      sampleEnable <= samplePhase & ~convAbort;
    end
  end

  // mux code maps straight to input 0..3
  assign muxSelect = channelSelect_r;
  assign referencePowerOff = referencePowerOff_r;
  assign convertActive = startBusy_r;
  assign conversionDone = conversionDoneFlag_r;
  assign readdata = readData_r;
  assign waitrequest = waitReq_r;

endmodule : adcc_conversion_control

// File: pkg/adcc_pkg.sv
// adcc_pkg: register map, field positions and timing of the converter control
package adcc_pkg;

  // =====================================================
  // bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // =====================================================
  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] RESULT_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h8;

  // =====================================================
  // adc_control_status field positions
  localparam int CHAN_LO_BIT = 0;
  localparam int CHAN_HI_BIT = 1;
  localparam int TIME_SEL_BIT = 2;
  localparam int BUSY_BIT = 3;
  localparam int DONE_BIT = 4;
  localparam int EXT_EN_BIT = 5;
  localparam int REF_OFF_BIT = 6;
  localparam int CHAN_W = 2;

  // status register field positions
  localparam int STATE_LO_BIT = 0;
  localparam int SAMPLING_BIT = 2;

  // =====================================================
  // reset values
  localparam logic [CHAN_W-1:0] CHAN_RESET = 2'h0;
  localparam logic [REG_W-1:0] RESULT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;

  // =====================================================
  // conversion timing, in machine cycles (one clk each)
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] SAMPLE_CYCLES = 6'h06;
  localparam logic [CNT_W-1:0] CONV_SHORT_CYCLES = 6'h18;
  localparam logic [CNT_W-1:0] CONV_LONG_CYCLES = 6'h30;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

  // =====================================================
  // conversion phases
  typedef enum logic [1:0] {
    ADCC_IDLE,
    ADCC_SAMPLE,
    ADCC_CONVERT
  } adcc_state_type;

endpackage : adcc_pkg

// File: logic/adcc_start_sync.sv
// adcc_start_sync: two-stage synchroniser and rising-edge detector for the start pin
`timescale 1ns/1ns
module adcc_start_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // asynchronous pin
  input wire logic pinIn,
  // one-cycle event
  output logic riseEvent
);

  // =====================================================
  // synchroniser
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // one event per low-to-high transition
  assign riseEvent = sync_r & ~prev_r;

endmodule : adcc_start_sync

// File: logic/adcc_conv_timer.sv
// adcc_conv_timer: cycle counter for the sampling and conversion phases
`timescale 1ns/1ns
module adcc_conv_timer
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic startPulse,
  input wire logic abortReq,
  input wire logic longSel,
  // phase outputs
  output logic samplePhase,
  output logic lastCycle
);

  // =====================================================
  // counter
  logic running_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] len_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      running_r <= 1'b0;
      cnt_r <= CNT_ZERO;
      len_r <= CONV_SHORT_CYCLES;
      samplePhase <= 1'b0;
    end else if (abortReq) begin
      running_r <= 1'b0;
      cnt_r <= CNT_ZERO;
      samplePhase <= 1'b0;
    end else if (startPulse) begin
      running_r <= 1'b1;
      cnt_r <= CNT_ZERO;
      len_r <= longSel ? CONV_LONG_CYCLES : CONV_SHORT_CYCLES;
      samplePhase <= 1'b1;
    end else if (running_r) begin
      cnt_r <= cnt_r + CNT_ONE;
      if (cnt_r == SAMPLE_CYCLES - CNT_ONE) begin
        samplePhase <= 1'b0;
      end
      if (lastCycle) begin
        running_r <= 1'b0;
      end
    end
  end

  // sampling is counted inside the total length
  assign lastCycle = running_r & (cnt_r == len_r - CNT_ONE);

endmodule : adcc_conv_timer

// File: bench/adcc_core_model.sv
// adcc_core_model: analog core, input multiplexer and start pin stand-in
`timescale 1ns/1ns
module adcc_core_model
  import adcc_pkg::*;
(
  // clock
  input wire logic clk,
  // bench controls
  input wire logic [31:0] levels,
  input wire logic pinReq,
  // design side
  input wire logic [adcc_pkg::CHAN_W-1:0] muxSelect,
  input wire logic referencePowerOff,
  input wire logic convertActive,
  output logic [adcc_pkg::REG_W-1:0] coreResult,
  output logic extStartPin
);
  logic [7:0] junkVal = 8'h5a;
  // toggles every cycle so an idle core never looks like a valid sample
  always @(posedge clk) begin
    junkVal <= ~junkVal ^ 8'h11;
  end
  // a level is offered only while converting with the reference on
  assign coreResult = (convertActive && !referencePowerOff) ? levels[muxSelect*8 +: 8] : junkVal;
  assign extStartPin = pinReq;
endmodule : adcc_core_model

// File: bench/adcc_conversion_control_chk.sv
// adcc_conversion_control_chk: port-level assertions for the converter control
`timescale 1ns/1ns
module adcc_conversion_control_chk
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus and system
  input wire logic [adcc_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [adcc_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic waitrequest,
  input wire logic powerDownMode,
  // converter side
  input wire logic [adcc_pkg::CHAN_W-1:0] muxSelect,
  input wire logic referencePowerOff,
  input wire logic sampleEnable,
  input wire logic convertActive,
  input wire logic conversionDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // =====================================================
  // busy length counter
  logic [6:0] busyCnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt_r <= 7'h00;
    end else begin
      busyCnt_r <= convertActive ? busyCnt_r + 7'h01 : 7'h00;
    end
  end
  sequence sSample;
    sampleEnable [*6] ##1 !sampleEnable;
  endsequence
  sequence sAccess;
    !waitrequest ##1 waitrequest;
  endsequence
  // =====================================================
  // properties
  a_never_both: assert property (!(convertActive && conversionDone))
    else $error("busy and done seen together");
  a_done_follows: assert property ($fell(convertActive) && !$past(powerDownMode) |-> conversionDone)
    else $error("done not set at end of conversion");
  a_done_source: assert property ($rose(conversionDone) |-> $past(convertActive))
    else $error("done set without a conversion");
  a_conv_length: assert property ($fell(convertActive) && !$past(powerDownMode)
    |-> busyCnt_r == 7'h18 || busyCnt_r == 7'h30)
    else $error("conversion length wrong");
  a_sample_phase: assert property ($rose(convertActive) |=> sSample)
    else $error("sampling phase not six cycles");
  a_start_gate: assert property ($rose(convertActive) |-> !$past(conversionDone) && !$past(powerDownMode))
    else $error("start while blocked");
  a_chan_frozen: assert property ((convertActive || conversionDone) && $past(convertActive || conversionDone)
    |-> $stable(muxSelect))
    else $error("channel changed while not idle");
  a_ref_write: assert property (write && !waitrequest && address == CTRL_ADDR && byteenable[0]
    |=> referencePowerOff == $past(writedata[REF_OFF_BIT]))
    else $error("reference power bit not applied");
  a_one_wait: assert property ((read || write) && waitrequest |=> sAccess)
    else $error("access not answered after one wait");
endmodule : adcc_conversion_control_chk

// File: bench/test_adc_conversion_control.sv
// test_adc_conversion_control: self-checking bench for the converter control
`timescale 1ns/1ns
module test_adc_conversion_control;
  import adcc_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic read = 1'h0;
  logic write = 1'h0;
  logic pinReq = 1'h0;
  logic powerDownMode = 1'h0;
  logic [ADDR_W-1:0] address = 4'h0;
  logic [DATA_W-1:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] levels = 32'h0;
  logic [DATA_W-1:0] readdata;
  logic [REG_W-1:0] coreResult, rd;
  logic [CHAN_W-1:0] muxSelect;
  logic waitrequest, extStartPin, referencePowerOff, sampleEnable, convertActive, conversionDone;
  integer errors = 0, n_compared = 0, seed = 32'hec63, cycles = 0, startCyc = 0, i;
  integer mChan = 0, mTsel = 0, mExt = 0, mRef = 0, mBusy = 0, mDone = 0, mRes = 0;
  adcc_conversion_control adcc_conversion_control_inst (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .extStartPin(extStartPin), .powerDownMode(powerDownMode), .coreResult(coreResult), .muxSelect(muxSelect),
    .referencePowerOff(referencePowerOff), .sampleEnable(sampleEnable), .convertActive(convertActive),
    .conversionDone(conversionDone));
  adcc_core_model adcc_core_model_inst (.clk(clk), .levels(levels), .pinReq(pinReq), .muxSelect(muxSelect),
    .referencePowerOff(referencePowerOff), .convertActive(convertActive), .coreResult(coreResult),
    .extStartPin(extStartPin));
  // =====================================================
  // clock, timeout and shared tasks
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // waits on waitrequest only; a hang is cut by the cycle ceiling
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'($random(seed)), d};
    byteenable <= {3'($random(seed)), 1'h1};
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'h0);
    rd = readdata[7:0];
    read <= 1'h0;
    write <= 1'h0;
    // one idle edge so a following call never re-raises a strobe in the same step
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] d);
    logic st;
    bus(1'h1, CTRL_ADDR, d);
    st = d[3] && !mBusy && !mDone && !powerDownMode;
    if (!mBusy && !mDone) mChan = d[1:0];
    if (st) startCyc = cycles - 1;
    mTsel = d[2];
    mExt = d[5];
    mRef = d[6];
    if (!d[4]) mDone = 0;
    if (st) mBusy = 1;
  endtask : wr
  task automatic rc;
    bus(1'h0, CTRL_ADDR, 8'h00);
    chk(rd, {1'h0, mRef[0], mExt[0], mDone[0], mBusy[0], mTsel[0], mChan[1:0]});
  endtask : rc
  task automatic conv(input logic timed);
    do begin
      @(posedge clk);
    end while (conversionDone !== 1'h1);
    if (timed) chk(cycles - startCyc, mTsel ? 49 : 25);
    mBusy = 0;
    mDone = 1;
    mRes = levels[mChan*8 +: 8];
  endtask : conv
  // =====================================================
  // main sequence
  initial begin
    levels = $random(seed);
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rc();
    bus(1'h0, RESULT_ADDR, 8'h00);
    chk(rd, 0);
    bus(1'h0, 4'hc, 8'h00);
    chk(rd, 0);
    wr(8'h90);
    rc();
    wr(8'h40);
    rc();
    chk(referencePowerOff, 1);
    wr(8'h00);
    for (i = 0; i < 4; i++) begin
      wr({4'h0, 1'h1, i[0], i[1:0]});
      rc();
      chk(muxSelect, i);
      wr({4'h0, 1'h0, i[0], ~i[1:0]});
      wr({4'h0, 1'h1, i[0], ~i[1:0]});
      rc();
      conv(1'h1);
      rc();
      levels <= $random(seed);
      bus(1'h0, RESULT_ADDR, 8'h00);
      chk(rd, mRes);
      wr({4'h0, 1'h1, i[0], i[1:0]});
      rc();
      wr({5'h00, i[0], i[1:0]});
      rc();
    end
    pinReq <= 1'h1;
    repeat (6) @(posedge clk);
    chk(convertActive, 0);
    pinReq <= 1'h0;
    wr(8'h20);
    pinReq <= 1'h1;
    repeat (5) @(posedge clk);
    chk(convertActive, 1);
    mBusy = 1;
    conv(1'h0);
    wr(8'h20);
    repeat (8) @(posedge clk);
    chk(convertActive, 0);
    pinReq <= 1'h0;
    wr(8'h28);
    repeat (10) @(posedge clk);
    powerDownMode <= 1'h1;
    repeat (2) @(posedge clk);
    mBusy = 0;
    wr(8'h28);
    rc();
    powerDownMode <= 1'h0;
    bus(1'h0, RESULT_ADDR, 8'h00);
    chk(rd, mRes);
    wr(8'h2c);
    conv(1'h1);
    powerDownMode <= 1'h1;
    repeat (3) @(posedge clk);
    rc();
    powerDownMode <= 1'h0;
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    mTsel = 0;
    mExt = 0;
    mDone = 0;
    mChan = 0;
    mRef = 0;
    mBusy = 0;
    @(posedge clk);
    rc();
    results();
  end
endmodule : test_adc_conversion_control
bind adcc_conversion_control adcc_conversion_control_chk adcc_conversion_control_chk_inst (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .waitrequest(waitrequest), .powerDownMode(powerDownMode), .muxSelect(muxSelect),
  .referencePowerOff(referencePowerOff), .sampleEnable(sampleEnable), .convertActive(convertActive),
  .conversionDone(conversionDone));
